// file: hpds_params.svh
// Constants for the heater process-data status block
`ifndef HPDS_PARAMS_SVH
`define HPDS_PARAMS_SVH

// ==================================================
// Register offsets (word index on the plain port)
`define HPDS_ADDR_W 4
`define HPDS_OFF_CFG 4'h0
`define HPDS_OFF_BAND 4'h1
`define HPDS_OFF_REC_IDX 4'h2
`define HPDS_OFF_REC_CALVAL 4'h3
`define HPDS_OFF_REC_CALTEMP 4'h4
`define HPDS_OFF_REC_CORR 4'h5
`define HPDS_OFF_REC_TCOEF 4'h6
`define HPDS_OFF_STATUS 4'h7

// ==================================================
// Configuration fields and reset values
`define HPDS_CFG_RANGE_BIT 0
`define HPDS_CFG_BAND_LSB 1
`define HPDS_CFG_RESET 16'h0002
`define HPDS_BAND_RESET 16'h0A0A
`define HPDS_BAND_MAX 8'h63

// ==================================================
// Status word bit positions
`define HPDS_ST_CAL_RUN 0
`define HPDS_ST_CAL_BLK 1
`define HPDS_ST_FAULT 2
`define HPDS_ST_CAUTION 3
`define HPDS_ST_GOAL 4
`define HPDS_ST_BAND 5
`define HPDS_ST_REG 6
`define HPDS_ST_SPARE 7
`define HPDS_ST_IDLE 8
`define HPDS_ST_NOSAMP 9
`define HPDS_ST_REC_LSB 10

// ==================================================
// Temperatures and timing
`define HPDS_CEIL_LOW 16'h012C
`define HPDS_CEIL_HIGH 16'h01F4
`define HPDS_START_INVALID 16'hFF9D
`define HPDS_GOAL_NUM 19
`define HPDS_GOAL_DEN 20
`define HPDS_INIT_TIME_MS 500
`define HPDS_CLK_KHZ 50000
`define HPDS_INIT_CYCLES (`HPDS_INIT_TIME_MS * `HPDS_CLK_KHZ)

`endif

// file: hpds_pkg.sv
// Types for the heater process-data status block
`default_nettype none
package hpds_pkg;

    // Band-check setting
    typedef enum logic [1:0] {
        HPDS_BAND_OFF = 2'h0,
        HPDS_BAND_LIVE = 2'h1,
        HPDS_BAND_LATCH = 2'h2
    } hpds_band_mode_t;

    // Zero-calibration sequencing, Gray along idle-run
    typedef enum logic [1:0] {
        HPDS_CAL_IDLE = 2'b00,
        HPDS_CAL_RUN = 2'b01
    } hpds_cal_state_t;

endpackage

`default_nettype wire

// file: hpds_top.sv
// Cyclic process-data logic of the heat-sealing temperature controller
`timescale 1ns/1ps
`default_nettype none
`include "hpds_params.svh"

module hpds_top #(
    parameter int unsigned INIT_CYCLES = `HPDS_INIT_CYCLES, // Init delay after clear
    parameter bit HAS_TEMPS = 1'b1,                         // Start temperature word present
    parameter int unsigned NUM_REC = 8                      // Calibration records
) (
    input wire logic core_clk,                     // System clock, 50 MHz
    input wire logic rst,                          // Asynchronous reset, active high
    // Cyclic input image
    input wire logic in_valid,                     // Provider status good and data present
    input wire logic heat_request,                 // Start heat cycle
    input wire logic clear_request,                // Fault reset request
    input wire logic sense_pause,                  // Measurement pause request
    input wire logic zero_cal_request,             // Zero calibration request
    input wire logic [2:0] cal_record_select,      // Requested calibration record
    input wire logic [15:0] set_point,             // Requested set point, degrees
    input wire logic exchange_strobe,              // One pulse per cyclic exchange
    // Internal device events
    input wire logic meas_done,                    // Measurement completed, pulse
    input wire logic meas_skipped,                 // Measurement skipped, pulse
    input wire logic [15:0] meas_temp,             // Measured temperature, signed
    input wire logic cal_done,                     // Zero calibration finished, pulse
    input wire logic element_cooling,              // Element still cooling
    input wire logic loop_closed,                  // Control loop has locked
    input wire logic alarm_raise,                  // Alarm event, pulse
    input wire logic alarm_warn,                   // Alarm is only a warning
    input wire logic [9:0] alarm_code,             // Cause of the alarm
    // Register port
    input wire logic [`HPDS_ADDR_W-1:0] reg_addr,  // Register index
    input wire logic [15:0] reg_wdata,             // Write data
    input wire logic reg_wr,                       // Write strobe
    input wire logic reg_rd,                       // Read strobe
    output logic [15:0] reg_rdata,                 // Read data, cycle after strobe
    // Output image
    output logic [15:0] out_actual,                // Word 1: actual value
    output logic [15:0] out_start_temp,            // Word 2: start temperature
    output logic [15:0] out_error,                 // Word 3: error code field
    output logic [15:0] out_status,                // Status flags and record
    // Towards the heater core
    output logic heat_enable,                      // Heat cycle accepted
    output logic cal_start,                        // Starts calibration, pulse
    output logic alarm_relay,                      // Alarm relay drive
    output logic [15:0] set_point_eff,             // Clamped set point
    output logic [2:0] active_record,              // Record in use
    output logic [15:0] rec_cal_value,             // Active record calibration value
    output logic [15:0] rec_cal_temp,              // Active record calibration temperature
    output logic [15:0] rec_corr,                  // Active record correction factor
    output logic [15:0] rec_tcoef                  // Active record temperature coefficient
);

    // ==================================================
    // Qualified input image
    logic heat_q, clear_q, pause_q, cal_q;
    logic [2:0] sel_q;
    logic [15:0] sp_q;

    // Whole image reads as zero when the provider status is bad
    assign heat_q = in_valid & heat_request;
    assign clear_q = in_valid & clear_request;
    assign pause_q = in_valid & sense_pause;
    assign cal_q = in_valid & zero_cal_request;
    assign sel_q = in_valid ? cal_record_select : 3'h0;
    assign sp_q = in_valid ? set_point : 16'h0000;

    // ==================================================
    // Configuration registers
    logic [15:0] cfg_reg;
    logic [15:0] band_reg;
    logic [2:0] rec_idx_reg;
    logic [7:0] wr_low, wr_high;
    hpds_pkg::hpds_band_mode_t band_mode;

    assign band_mode = hpds_pkg::hpds_band_mode_t'(cfg_reg[`HPDS_CFG_BAND_LSB +: 2]);
    // Widths above the limit are cut back rather than refused
    assign wr_low = (reg_wdata[7:0] > `HPDS_BAND_MAX) ? `HPDS_BAND_MAX : reg_wdata[7:0];
    assign wr_high = (reg_wdata[15:8] > `HPDS_BAND_MAX) ? `HPDS_BAND_MAX : reg_wdata[15:8];

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cfg_reg <= `HPDS_CFG_RESET;
            band_reg <= `HPDS_BAND_RESET;
            rec_idx_reg <= 3'h0;
        end else if (reg_wr) begin
            case (reg_addr)
                `HPDS_OFF_CFG: cfg_reg <= {13'h0000, reg_wdata[2:0]};
                `HPDS_OFF_BAND: band_reg <= {wr_high, wr_low};
                `HPDS_OFF_REC_IDX: rec_idx_reg <= reg_wdata[2:0];
                default: ;
            endcase
        end
    end

    // ==================================================
    // Calibration record store, one row per record
    logic [15:0] cal_val_mem [NUM_REC];
    logic [15:0] cal_temp_mem [NUM_REC];
    logic [15:0] corr_mem [NUM_REC];
    logic [15:0] tcoef_mem [NUM_REC];

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < NUM_REC; i++) begin
                cal_val_mem[i] <= 16'h0000;
                cal_temp_mem[i] <= 16'h0000;
                corr_mem[i] <= 16'h0000;
                tcoef_mem[i] <= 16'h0000;
            end
        end else if (reg_wr) begin
            case (reg_addr)
                `HPDS_OFF_REC_CALVAL: cal_val_mem[rec_idx_reg] <= reg_wdata;
                `HPDS_OFF_REC_CALTEMP: cal_temp_mem[rec_idx_reg] <= reg_wdata;
                `HPDS_OFF_REC_CORR: corr_mem[rec_idx_reg] <= reg_wdata;
                `HPDS_OFF_REC_TCOEF: tcoef_mem[rec_idx_reg] <= reg_wdata;
                default: ;
            endcase
        end
    end

    // ==================================================
    // Zero calibration and record lock
    hpds_pkg::hpds_cal_state_t cal_state_reg;
    logic cal_blocked_live;
    logic fault_reg;

    // Clear request also blocks: the power unit is off while it is held
    assign cal_blocked_live = heat_q | element_cooling | clear_q;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cal_state_reg <= hpds_pkg::HPDS_CAL_IDLE;
            active_record <= 3'h0;
            cal_start <= 1'b0;
        end else begin
            cal_start <= 1'b0;
            unique case (cal_state_reg)
                hpds_pkg::HPDS_CAL_IDLE: begin
                    active_record <= sel_q;
                    if (cal_q && !cal_blocked_live && !fault_reg) begin
                        cal_state_reg <= hpds_pkg::HPDS_CAL_RUN;
                        cal_start <= 1'b1;
                    end
                end
                hpds_pkg::HPDS_CAL_RUN: begin
                    // Record frozen until the calibration ends
                    if (cal_done) begin
                        cal_state_reg <= hpds_pkg::HPDS_CAL_IDLE;
                    end
                end
            endcase
        end
    end

    logic cal_run;
    assign cal_run = (cal_state_reg == hpds_pkg::HPDS_CAL_RUN);

    // Record fields of the record in use, registered for the heater core
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rec_cal_value <= 16'h0000;
            rec_cal_temp <= 16'h0000;
            rec_corr <= 16'h0000;
            rec_tcoef <= 16'h0000;
        end else begin
            rec_cal_value <= cal_val_mem[active_record];
            rec_cal_temp <= cal_temp_mem[active_record];
            rec_corr <= corr_mem[active_record];
            rec_tcoef <= tcoef_mem[active_record];
        end
    end

    // ==================================================
    // Set point clamp
    logic [15:0] ceiling;
    assign ceiling = cfg_reg[`HPDS_CFG_RANGE_BIT] ? `HPDS_CEIL_HIGH : `HPDS_CEIL_LOW;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            set_point_eff <= 16'h0000;
        end else begin
            set_point_eff <= ($signed(sp_q) > $signed(ceiling)) ? ceiling : sp_q;
        end
    end

    // ==================================================
    // Fault latch and init timer after clear
    logic clear_d_reg;
    logic [31:0] init_cnt_reg;
    logic caution_reg;
    logic [9:0] err_code_reg;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            fault_reg <= 1'b0;
            caution_reg <= 1'b0;
            err_code_reg <= 10'h000;
        end else if (alarm_raise) begin
            // A new alarm wins over a clear in the same cycle
            fault_reg <= 1'b1;
            caution_reg <= alarm_warn;
            err_code_reg <= alarm_code;
        end else if (clear_q) begin
            fault_reg <= 1'b0;
            caution_reg <= 1'b0;
            err_code_reg <= 10'h000;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            clear_d_reg <= 1'b0;
            init_cnt_reg <= 32'h00000000;
        end else begin
            clear_d_reg <= clear_q;
            if (clear_d_reg && !clear_q) begin
                init_cnt_reg <= INIT_CYCLES;
            end else if (init_cnt_reg != 32'h00000000) begin
                init_cnt_reg <= init_cnt_reg - 32'h00000001;
            end
        end
    end

    // Relay stays quiet for warnings
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            alarm_relay <= 1'b0;
        end else begin
            alarm_relay <= fault_reg & ~caution_reg;
        end
    end

    // ==================================================
    // Heat cycle acceptance and regulation
    logic heat_ok, heat_d_reg, heat_rise;
    logic regulating_reg;

    assign heat_ok = heat_q & ~cal_run & ~fault_reg & ~clear_q & (init_cnt_reg == 32'h00000000);
    assign heat_rise = heat_q & ~heat_d_reg;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            heat_d_reg <= 1'b0;
            heat_enable <= 1'b0;
            regulating_reg <= 1'b0;
        end else begin
            heat_d_reg <= heat_q;
            // Lost provider drops the request and so aborts the cycle
            heat_enable <= heat_ok;
            regulating_reg <= heat_enable & heat_ok & loop_closed;
        end
    end

    // ==================================================
    // Temperature evaluation
    logic signed [15:0] temp_reg;
    logic signed [15:0] start_temp_reg;
    logic signed [21:0] t_scaled, sp_scaled;
    logic signed [16:0] band_lo, band_hi;
    logic in_band, goal_reg, band_reg_flag, band_armed_reg, nosamp_reg, first_meas_reg;

    assign t_scaled = 22'($signed(temp_reg)) * 22'sd20;
    assign sp_scaled = 22'($signed(set_point_eff)) * 22'sd19;
    assign band_lo = 17'($signed(set_point_eff)) - 17'($signed({1'b0, band_reg[7:0]}));
    assign band_hi = 17'($signed(set_point_eff)) + 17'($signed({1'b0, band_reg[15:8]}));
    assign in_band = (17'(temp_reg) >= band_lo) && (17'(temp_reg) <= band_hi);

    // Latest measurement and start temperature
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            temp_reg <= 16'sh0000;
            start_temp_reg <= 16'sh0000;
            first_meas_reg <= 1'b0;
        end else begin
            if (meas_done) begin
                temp_reg <= $signed(meas_temp);
                first_meas_reg <= 1'b1;
            end
            if (heat_ok && !heat_enable) begin
                start_temp_reg <= temp_reg;
            end
        end
    end

    // Goal flag, cleared by stop or fault; alarm edge clears it so no snapshot shows both
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            goal_reg <= 1'b0;
        end else if (!heat_q || fault_reg || alarm_raise) begin
            goal_reg <= 1'b0;
        end else if (t_scaled > sp_scaled) begin
            goal_reg <= 1'b1;
        end
    end

    // Band flag in its three settings
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            band_reg_flag <= 1'b0;
            band_armed_reg <= 1'b0;
        end else begin
            unique case (band_mode)
                hpds_pkg::HPDS_BAND_LIVE: band_reg_flag <= in_band;
                hpds_pkg::HPDS_BAND_LATCH: begin
                    if (heat_rise) begin
                        band_armed_reg <= 1'b1;
                        band_reg_flag <= in_band;
                    end else if (heat_q) begin
                        if (band_armed_reg && in_band) begin
                            band_reg_flag <= 1'b1;
                            band_armed_reg <= 1'b0;
                        end else if (!in_band) begin
                            band_reg_flag <= 1'b0;
                        end
                    end
                end
                default: band_reg_flag <= 1'b0;
            endcase
        end
    end

    // Measurement interruption, a fresh sample wins
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            nosamp_reg <= 1'b0;
        end else if (meas_done || !heat_q) begin
            nosamp_reg <= 1'b0;
        end else if (meas_skipped) begin
            nosamp_reg <= 1'b1;
        end
    end

    // ==================================================
    // Standby handshake
    logic idle_reg;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            idle_reg <= 1'b0;
        end else begin
            // Pause only counts when no heat or calibration is pending; a clear request sets idle by itself
            idle_reg <= clear_q | (pause_q & ~heat_q & ~cal_q & ~cal_run);
        end
    end

    // ==================================================
    // Live status word
    logic [15:0] status_live;
    always_comb begin
        status_live = 16'h0000;
        status_live[`HPDS_ST_CAL_RUN] = cal_run;
        status_live[`HPDS_ST_CAL_BLK] = cal_blocked_live;
        status_live[`HPDS_ST_FAULT] = fault_reg;
        status_live[`HPDS_ST_CAUTION] = caution_reg;
        status_live[`HPDS_ST_GOAL] = goal_reg;
        status_live[`HPDS_ST_BAND] = band_reg_flag;
        status_live[`HPDS_ST_REG] = regulating_reg;
        status_live[`HPDS_ST_SPARE] = 1'b0;
        status_live[`HPDS_ST_IDLE] = idle_reg;
        status_live[`HPDS_ST_NOSAMP] = nosamp_reg;
        status_live[`HPDS_ST_REC_LSB +: 3] = active_record;
        if (!first_meas_reg) begin
            status_live = 16'h0000;
        end
    end

    // ==================================================
    // Output image, one snapshot per exchange
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            out_actual <= 16'h0000;
            out_start_temp <= 16'h0000;
            out_error <= 16'h0000;
            out_status <= 16'h0000;
        end else if (exchange_strobe) begin
            out_status <= status_live;
            out_actual <= (cal_run || fault_reg) ? 16'h0000 : temp_reg;
            if (!HAS_TEMPS) begin
                out_start_temp <= 16'h0000;
            end else begin
                out_start_temp <= heat_q ? start_temp_reg : `HPDS_START_INVALID;
            end
            out_error <= first_meas_reg ? {6'h00, err_code_reg} : 16'h0000;
        end
    end

    // ==================================================
    // Register read port, data one cycle after the strobe
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            case (reg_addr)
                `HPDS_OFF_CFG: reg_rdata <= cfg_reg;
                `HPDS_OFF_BAND: reg_rdata <= band_reg;
                `HPDS_OFF_REC_IDX: reg_rdata <= {13'h0000, rec_idx_reg};
                `HPDS_OFF_REC_CALVAL: reg_rdata <= cal_val_mem[rec_idx_reg];
                `HPDS_OFF_REC_CALTEMP: reg_rdata <= cal_temp_mem[rec_idx_reg];
                `HPDS_OFF_REC_CORR: reg_rdata <= corr_mem[rec_idx_reg];
                `HPDS_OFF_REC_TCOEF: reg_rdata <= tcoef_mem[rec_idx_reg];
                `HPDS_OFF_STATUS: reg_rdata <= status_live;
                default: reg_rdata <= 16'h0000;
            endcase
        end else begin
            reg_rdata <= 16'h0000;
        end
    end

endmodule // hpds_top

`default_nettype wire

// file: hpds_top_monitor.sv
// Concurrent checks on the process-data block ports
`timescale 1ns/1ps
`default_nettype none
// ==========
// Checker
module hpds_mon (
    input wire logic core_clk, // Clock
    input wire logic rst, // Reset
    input wire logic in_valid, // Image good
    input wire logic heat_request, // Heat level
    input wire logic [15:0] set_point, // Requested set point
    input wire logic exchange_strobe, // Exchange pulse
    input wire logic cal_done, // Calibration end
    input wire logic cal_start, // Calibration start
    input wire logic heat_enable, // Heat accepted
    input wire logic alarm_relay, // Relay drive
    input wire logic [15:0] set_point_eff, // Clamped set point
    input wire logic [2:0] active_record, // Record in use
    input wire logic [15:0] out_actual, // Actual word
    input wire logic [15:0] out_start_temp, // Start word
    input wire logic [15:0] out_status // Status word
);
    logic cal_on;
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    // Tracks a running calibration from its start pulse
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) cal_on <= 1'b0;
        else if (cal_start) cal_on <= 1'b1;
        else if (cal_done) cal_on <= 1'b0;
    end
    sequence s_cal_hold;
        cal_on && !cal_done;
    endsequence
    chk_spare_low: assert property (out_status[7] == 1'b0) else $error("spare bit set");
    chk_image_hold: assert property (!exchange_strobe |=> $stable(out_status) && $stable(out_actual))
        else $error("image moved between exchanges");
    chk_goal_fault: assert property (out_status[2] |-> !out_status[4]) else $error("goal with fault");
    chk_actual_zero: assert property ((out_status[2] || out_status[0]) |-> out_actual == 16'h0000)
        else $error("actual not zero");
    chk_start_bad: assert property (exchange_strobe && !heat_request |=> out_start_temp == 16'hFF9D)
        else $error("start word not invalid");
    chk_sp_clamp: assert property (in_valid && $signed(set_point) > $signed(16'h01F4)
        |=> set_point_eff inside {16'h012C, 16'h01F4}) else $error("set point not clamped");
    chk_cal_record: assert property (s_cal_hold |=> $stable(active_record)) else $error("record moved");
    chk_reg_heat: assert property ($rose(out_status[6]) |-> $past(heat_enable)) else $error("early regulate");
    chk_warn_relay: assert property (out_status[3] |-> !alarm_relay) else $error("relay on warning");
endmodule // hpds_mon
bind hpds_top hpds_mon mon (.core_clk, .rst, .in_valid, .heat_request, .set_point, .exchange_strobe,
    .cal_done, .cal_start, .heat_enable, .alarm_relay, .set_point_eff, .active_record, .out_actual,
    .out_start_temp, .out_status);
`default_nettype wire

// file: hpds_plc_model.sv
// Fieldbus controller model: exchange pulses and clear handshake
`timescale 1ns/1ps
`default_nettype none
// ==========
// Controller
module hpds_plc_model (
    input wire logic core_clk, // Clock
    input wire logic rst, // Reset
    input wire logic clr_go, // Bench asks for a clear
    input wire logic idle_seen, // Acknowledge from image
    output logic clear_request, // Clear level
    output logic exchange_strobe // One pulse every four cycles
);
    logic [1:0] div;
    // Cyclic exchange every fourth clock
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) div <= 2'h0;
        else div <= div + 2'h1;
    end
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) exchange_strobe <= 1'b0;
        else exchange_strobe <= (div == 2'h3);
    end
    // Request held until acknowledged, never dropped early
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) clear_request <= 1'b0;
        else if (clr_go) clear_request <= 1'b1;
        else if (idle_seen) clear_request <= 1'b0;
    end
endmodule // hpds_plc_model
`default_nettype wire

// file: hpds_top_tb.sv
// Self-checking bench for the process-data block
`timescale 1ns/1ps
`default_nettype none
`include "hpds_params.svh"
// ==========
// Bench
module hpds_top_tb;
    logic core_clk = 1'b0, rst = 1'b1, in_valid = 1'b1, heat_request = 1'b0, sense_pause = 1'b0;
    logic zero_cal_request = 1'b0, meas_done = 1'b0, meas_skipped = 1'b0, cal_done = 1'b0, element_cooling = 1'b0;
    logic loop_closed = 1'b0, alarm_raise = 1'b0, alarm_warn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, clr_go = 1'b0;
    logic [2:0] cal_record_select = 3'h0;
    logic [15:0] set_point = 16'h0000, meas_temp = 16'h0000, reg_wdata = 16'h0000;
    logic [9:0] alarm_code = 10'h000;
    logic [`HPDS_ADDR_W-1:0] reg_addr = 4'h0;
    logic clear_request, exchange_strobe, heat_enable, cal_start, alarm_relay;
    logic [15:0] reg_rdata, out_actual, out_start_temp, out_error, out_status, set_point_eff;
    logic [15:0] rec_cal_value, rec_cal_temp, rec_corr, rec_tcoef;
    logic [2:0] active_record;
    int bad_count = 0;
    int compares = 0;
    always #10 core_clk = ~core_clk;
    hpds_top #(.INIT_CYCLES(20)) uut (.*);
    hpds_plc_model plc (.core_clk, .rst, .clr_go, .idle_seen(out_status[8]), .clear_request, .exchange_strobe);
    task summarize;
        $display("compares=%0d bad_count=%0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Two exchanges, so flags settle before the snapshot is read
    task snap;
        int n;
        repeat (2) begin
            n = 0;
            #1;
            while (exchange_strobe !== 1'b1 && n < 16) begin
                @(negedge core_clk);
                n++;
            end
            if (n >= 16) begin
                bad_count++;
                summarize();
            end
            @(posedge core_clk);
        end
        #1;
    endtask
    task wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge core_clk) begin reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1; end
        @(posedge core_clk) reg_wr <= 1'b0;
    endtask
    task rd(input logic [3:0] a, input logic [15:0] exp);
        @(posedge core_clk) begin reg_addr <= a; reg_rd <= 1'b1; end
        @(posedge core_clk) reg_rd <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask
    task meas(input logic [15:0] t);
        @(posedge core_clk) begin meas_temp <= t; meas_done <= 1'b1; end
        @(posedge core_clk) meas_done <= 1'b0;
    endtask
    initial begin
        repeat (10) @(posedge core_clk);
        rst <= 1'b0;
        rd(`HPDS_OFF_CFG, `HPDS_CFG_RESET);
        rd(`HPDS_OFF_BAND, `HPDS_BAND_RESET);
        rd(4'hF, 16'h0000);
        wr(`HPDS_OFF_BAND, 16'hFF64);
        rd(`HPDS_OFF_BAND, 16'h6363);
        wr(`HPDS_OFF_REC_CALVAL, 16'hABCD);
        rd(`HPDS_OFF_REC_CALVAL, 16'hABCD);
        $display("registers done");
        @(posedge core_clk) set_point <= 16'h0258;
        meas(16'h0014);
        snap;
        chk(set_point_eff, `HPDS_CEIL_LOW);
        chk(rec_cal_value, 16'hABCD);
        chk(out_actual, 16'h0014);
        chk(out_start_temp, `HPDS_START_INVALID);
        chk(out_status, 16'h0000);
        wr(`HPDS_OFF_CFG, 16'h0003);
        snap;
        chk(set_point_eff, `HPDS_CEIL_HIGH);
        @(posedge core_clk) begin set_point <= 16'h012C; heat_request <= 1'b1; loop_closed <= 1'b1; end
        meas(16'h0122);
        snap;
        chk(out_status, 16'h0072);
        chk(out_start_temp, 16'h0014);
        wr(`HPDS_OFF_CFG, 16'h0001);
        snap;
        chk(out_status, 16'h0052);
        @(posedge core_clk) heat_request <= 1'b0;
        snap;
        chk(out_status, 16'h0000);
        $display("heat done");
        wr(`HPDS_OFF_CFG, 16'h0005);
        @(posedge core_clk) heat_request <= 1'b1;
        snap;
        chk(out_status, 16'h0072);
        @(posedge core_clk) heat_request <= 1'b0;
        meas(16'h0064);
        snap;
        chk(out_status, 16'h0020);
        $display("latch done");
        @(posedge core_clk) begin alarm_raise <= 1'b1; alarm_warn <= 1'b1; alarm_code <= 10'h123; end
        @(posedge core_clk) alarm_raise <= 1'b0;
        snap;
        chk(out_status & 16'hFFDF, 16'h000C);
        chk(out_error, 16'h0123);
        chk(out_actual, 16'h0000);
        chk({15'h0000, alarm_relay}, 16'h0000);
        @(posedge core_clk) clr_go <= 1'b1;
        @(posedge core_clk) clr_go <= 1'b0;
        snap;
        snap;
        chk({15'h0000, clear_request}, 16'h0000);
        chk(out_status & 16'hFFDF, 16'h0000);
        $display("fault done");
        @(posedge core_clk) begin cal_record_select <= 3'h5; zero_cal_request <= 1'b1; end
        snap;
        chk(out_status & 16'hFFDF, 16'h1401);
        @(posedge core_clk) cal_record_select <= 3'h2;
        snap;
        chk(out_status & 16'hFFDF, 16'h1401);
        chk({13'h0000, active_record}, 16'h0005);
        @(posedge core_clk) begin zero_cal_request <= 1'b0; cal_done <= 1'b1; end
        @(posedge core_clk) cal_done <= 1'b0;
        snap;
        chk(out_status & 16'hFFDF, 16'h0800);
        @(posedge core_clk) begin in_valid <= 1'b0; heat_request <= 1'b1; end
        snap;
        chk({15'h0000, heat_enable}, 16'h0000);
        @(posedge core_clk) in_valid <= 1'b1;
        snap;
        chk({15'h0000, heat_enable}, 16'h0001);
        @(posedge core_clk) meas_skipped <= 1'b1;
        @(posedge core_clk) meas_skipped <= 1'b0;
        snap;
        chk(out_status & 16'h0200, 16'h0200);
        meas(16'h0064);
        snap;
        chk(out_status & 16'h0200, 16'h0000);
        $display("calibration and input image done");
        summarize();
    end
endmodule // hpds_top_tb
`default_nettype wire
